// File: hdl/tx_bus_parity_pin_mux.sv
`timescale 1ns/1ps
`include "tx_bus_parity_regs.svh"

module tx_bus_parity_pin_mux #(
   parameter int DATA_WIDTH      = 8,
   parameter int ERR_COUNT_WIDTH = 8
) (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          reset,
   // register port
   input  wire tx_bus_parity_pkg::reg_addr_t  regAddr,
   input  wire tx_bus_parity_pkg::reg_byte_t  regWrData,
   input  wire logic                          regWr,
   input  wire logic                          regRd,
   output      tx_bus_parity_pkg::reg_byte_t  regRdData,
   // pins from the bus source or line interface
   input  wire logic                          sharedPinIn,
   input  wire logic [DATA_WIDTH-1:0]         txBusDataCh2,
   input  wire logic                          txBusPayloadIndCh2,
   input  wire logic                          txBusPathStartIndCh2,
   // towards the ingress frame synchronizer
   output      logic                          ingressCodeViolationCh6,
   output      logic                          ingressNegRailCh6,
   // status
   output      logic                          parityErrorPulse,
   output      tx_bus_parity_pkg::pin_role_t  pinRole,
   output      logic                          irq
);

   // ****************************************
   // elaboration checks
   // ****************************************
   if (DATA_WIDTH != 8) begin : g_badDataWidth
      $error("tx bus data width must be eight");
   end
   if (ERR_COUNT_WIDTH < 1 || ERR_COUNT_WIDTH > 8) begin : g_badCountWidth
      $error("error counter must be one to eight bits");
   end

   // ****************************************
   // functions
   // ****************************************
   function automatic logic calcParity(
      input logic [DATA_WIDTH-1:0] data,
      input logic                  payloadInd,
      input logic                  pathStartInd,
      input logic                  wideScope,
      input logic                  oddSense
   );
      logic p;
      p = ^data;
      if (wideScope) begin
         p = p ^ payloadInd ^ pathStartInd;
      end
      return oddSense ? ~p : p;
   endfunction : calcParity

   function automatic logic hit(
      input tx_bus_parity_pkg::reg_addr_t a,
      input tx_bus_parity_pkg::reg_addr_t ofs
   );
      return a == ofs;
   endfunction : hit

   // ****************************************
   // pin synchronisers
   // ****************************************
   // all pins pass the same two stages so data and parity stay aligned
   logic                  pinMeta;
   logic                  pinSync;
   logic [DATA_WIDTH-1:0] dataMeta;
   logic [DATA_WIDTH-1:0] dataSync;
   logic                  payloadMeta;
   logic                  payloadSync;
   logic                  pathStartMeta;
   logic                  pathStartSync;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pinMeta       <= 1'b0;
         pinSync       <= 1'b0;
         dataMeta      <= '0;
         dataSync      <= '0;
         payloadMeta   <= 1'b0;
         payloadSync   <= 1'b0;
         pathStartMeta <= 1'b0;
         pathStartSync <= 1'b0;
      end else begin
         pinMeta       <= sharedPinIn;
         pinSync       <= pinMeta;
         dataMeta      <= txBusDataCh2;
         dataSync      <= dataMeta;
         payloadMeta   <= txBusPayloadIndCh2;
         payloadSync   <= payloadMeta;
         pathStartMeta <= txBusPathStartIndCh2;
         pathStartSync <= pathStartMeta;
      end
   end

   // ****************************************
   // register decode
   // ****************************************
   tx_bus_parity_pkg::reg_byte_t ifCtrlByte2;
   tx_bus_parity_pkg::reg_byte_t chanCtrl;
   tx_bus_parity_pkg::reg_byte_t irqStatus;
   tx_bus_parity_pkg::reg_byte_t irqEnable;
   tx_bus_parity_pkg::reg_byte_t indirectHi;
   tx_bus_parity_pkg::reg_byte_t indirectLo;
   logic [ERR_COUNT_WIDTH-1:0]   parityErrCount;

   logic indirectHitsCtrl;
   logic wrIfCtrl;
   logic wrIrqClear;

   assign indirectHitsCtrl = (indirectHi == `IND_IF_CTRL_HI) && (indirectLo == `IND_IF_CTRL_LO);
   assign wrIfCtrl         = regWr && (hit(regAddr, `OFS_IF_CTRL_BYTE2) ||
                                       (hit(regAddr, `OFS_INDIRECT_DATA) && indirectHitsCtrl));
   assign wrIrqClear       = regWr && hit(regAddr, `OFS_IRQ_CLEAR);

   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ifCtrlByte2 <= `RST_IF_CTRL_BYTE2;
      end else if (wrIfCtrl) begin
         ifCtrlByte2 <= regWrData;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         chanCtrl <= `RST_CHAN_CTRL;
      end else if (regWr && hit(regAddr, `OFS_CHAN_CTRL)) begin
         chanCtrl <= regWrData;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irqEnable <= `RST_IRQ;
      end else if (regWr && hit(regAddr, `OFS_IRQ_ENABLE)) begin
         irqEnable <= regWrData;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         indirectHi <= `RST_BYTE;
         indirectLo <= `RST_BYTE;
      end else if (regWr) begin
         if (hit(regAddr, `OFS_INDIRECT_HI)) begin
            indirectHi <= regWrData;
         end
         if (hit(regAddr, `OFS_INDIRECT_LO)) begin
            indirectLo <= regWrData;
         end
      end
   end

   // ****************************************
   // pin role selection
   // ****************************************
   logic busEnable;
   logic framerEnable;
   logic dualRail;
   logic ingressPath;

   assign busEnable    = chanCtrl[`CHC_BUS_EN_BIT];
   assign framerEnable = chanCtrl[`CHC_FRAMER_EN_BIT];
   assign dualRail     = chanCtrl[`CHC_DUAL_RAIL_BIT];
   assign ingressPath  = chanCtrl[`CHC_INGRESS_BIT];

   // the bus always wins, even if software also enables the framer
   always_comb begin
      if (busEnable) begin
         pinRole = tx_bus_parity_pkg::ROLE_PARITY;
      end else if (framerEnable && ingressPath) begin
         if (dualRail) begin
            pinRole = tx_bus_parity_pkg::ROLE_NEG_RAIL;
         end else begin
            pinRole = tx_bus_parity_pkg::ROLE_CODE_VIOL;
         end
      end else begin
         pinRole = tx_bus_parity_pkg::ROLE_IDLE;
      end
   end

   // ****************************************
   // parity check and framer outputs
   // ****************************************
   logic expectedParity;
   logic parityMismatch;
   logic codeViolEvent;

   assign expectedParity = calcParity(dataSync, payloadSync, pathStartSync,
                                      ifCtrlByte2[`IFC_SCOPE_BIT], ifCtrlByte2[`IFC_ODD_BIT]);
   // every clock is one bus byte cycle; no byte qualifier exists
   assign parityMismatch = (pinRole == tx_bus_parity_pkg::ROLE_PARITY) &&
                           (pinSync != expectedParity);
   assign codeViolEvent  = (pinRole == tx_bus_parity_pkg::ROLE_CODE_VIOL) && pinSync;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         parityErrorPulse <= 1'b0;
      end else begin
         parityErrorPulse <= parityMismatch;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ingressCodeViolationCh6 <= 1'b0;
         ingressNegRailCh6       <= 1'b0;
      end else begin
         ingressCodeViolationCh6 <= 1'b0;
         ingressNegRailCh6       <= 1'b0;
         unique case (pinRole)
            tx_bus_parity_pkg::ROLE_IDLE: begin
            end
            tx_bus_parity_pkg::ROLE_PARITY: begin
            end
            tx_bus_parity_pkg::ROLE_CODE_VIOL: begin
               ingressCodeViolationCh6 <= pinSync;
            end
            tx_bus_parity_pkg::ROLE_NEG_RAIL: begin
               ingressNegRailCh6 <= pinSync;
            end
         endcase
      end
   end

   // saturating so a long error burst never wraps back to small
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         parityErrCount <= '0;
      end else if (parityMismatch && !(&parityErrCount)) begin
         parityErrCount <= parityErrCount + 1'b1;
      end
   end

   // ****************************************
   // interrupt status
   // ****************************************
   // set wins over a clear in the same cycle
   tx_bus_parity_pkg::reg_byte_t irqSet;
   tx_bus_parity_pkg::reg_byte_t irqClr;

   always_comb begin
      irqSet = '0;
      irqSet[`IRQ_PARITY_BIT]    = parityMismatch;
      irqSet[`IRQ_CODE_VIOL_BIT] = codeViolEvent;
      irqClr = wrIrqClear ? regWrData : '0;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irqStatus <= `RST_IRQ;
      end else begin
         irqStatus <= (irqStatus & ~irqClr) | irqSet;
      end
   end

   assign irq = |(irqStatus & irqEnable);

   // ****************************************
   // read data
   // ****************************************
   tx_bus_parity_pkg::reg_byte_t next_regRdData;
   tx_bus_parity_pkg::reg_byte_t liveState;
   tx_bus_parity_pkg::reg_byte_t countByte;

   always_comb begin
      liveState      = '0;
      liveState[`LIVE_ROLE_HI:`LIVE_ROLE_LO] = pinRole;
      liveState[`LIVE_PIN_BIT] = pinSync;
      liveState[`LIVE_EXP_BIT] = expectedParity;
      countByte      = '0;
      countByte[ERR_COUNT_WIDTH-1:0] = parityErrCount;
   end

   always_comb begin
      next_regRdData = '0;
      if (hit(regAddr, `OFS_IF_CTRL_BYTE2)) begin
         next_regRdData = ifCtrlByte2;
      end else if (hit(regAddr, `OFS_CHAN_CTRL)) begin
         next_regRdData = chanCtrl;
      end else if (hit(regAddr, `OFS_IRQ_STATUS)) begin
         next_regRdData = irqStatus;
      end else if (hit(regAddr, `OFS_IRQ_ENABLE)) begin
         next_regRdData = irqEnable;
      end else if (hit(regAddr, `OFS_LIVE_STATE)) begin
         next_regRdData = liveState;
      end else if (hit(regAddr, `OFS_PARITY_ERR_COUNT)) begin
         next_regRdData = countByte;
      end else if (hit(regAddr, `OFS_INDIRECT_HI)) begin
         next_regRdData = indirectHi;
      end else if (hit(regAddr, `OFS_INDIRECT_LO)) begin
         next_regRdData = indirectLo;
      end else if (hit(regAddr, `OFS_INDIRECT_DATA) && indirectHitsCtrl) begin
         next_regRdData = ifCtrlByte2;
      end
   end

   // data stands one cycle only, zero otherwise
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         regRdData <= `RST_BYTE;
      end else if (regRd) begin
         regRdData <= next_regRdData;
      end else begin
         regRdData <= `RST_BYTE;
      end
   end

endmodule : tx_bus_parity_pin_mux

// File: hdl/tx_bus_parity_regs.svh
`ifndef TX_BUS_PARITY_REGS_SVH
`define TX_BUS_PARITY_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_IF_CTRL_BYTE2     16'h0139
`define OFS_CHAN_CTRL         16'h0140
`define OFS_IRQ_STATUS        16'h0141
`define OFS_IRQ_ENABLE        16'h0142
`define OFS_IRQ_CLEAR         16'h0143
`define OFS_LIVE_STATE        16'h0144
`define OFS_PARITY_ERR_COUNT  16'h0145
`define OFS_INDIRECT_HI       16'h0146
`define OFS_INDIRECT_LO       16'h0147
`define OFS_INDIRECT_DATA     16'h0148

// indirect pair that reaches the control byte
`define IND_IF_CTRL_HI        8'h00
`define IND_IF_CTRL_LO        8'h39

// ****************************************
// field positions
// ****************************************
`define IFC_ODD_BIT           0
`define IFC_SCOPE_BIT         1
`define CHC_BUS_EN_BIT        0
`define CHC_FRAMER_EN_BIT     1
`define CHC_DUAL_RAIL_BIT     2
`define CHC_INGRESS_BIT       3
`define IRQ_PARITY_BIT        0
`define IRQ_CODE_VIOL_BIT     1
`define LIVE_ROLE_HI          1
`define LIVE_ROLE_LO          0
`define LIVE_PIN_BIT          2
`define LIVE_EXP_BIT          3

// ****************************************
// reset values
// ****************************************
`define RST_IF_CTRL_BYTE2     8'h00
`define RST_CHAN_CTRL         8'h00
`define RST_IRQ               8'h00
`define RST_BYTE              8'h00

`endif

// File: hdl/tx_bus_parity_pkg.sv
package tx_bus_parity_pkg;

   // ****************************************
   // role of the shared pin
   // ****************************************
   typedef enum logic [1:0] {
      ROLE_IDLE      = 2'b00,
      ROLE_PARITY    = 2'b01,
      ROLE_CODE_VIOL = 2'b10,
      ROLE_NEG_RAIL  = 2'b11
   } pin_role_t;

   typedef logic [7:0]  reg_byte_t;
   typedef logic [15:0] reg_addr_t;

endpackage : tx_bus_parity_pkg

// File: dv/tx_bus_parity_props.sv
`timescale 1ns/1ps
`include "tx_bus_parity_regs.svh"

module tx_bus_parity_props #(
   parameter int DATA_WIDTH      = 8,
   parameter int ERR_COUNT_WIDTH = 8
) (
   // clock and reset
   input wire logic                         clk,
   input wire logic                         reset,
   // register port
   input wire tx_bus_parity_pkg::reg_addr_t regAddr,
   input wire tx_bus_parity_pkg::reg_byte_t regWrData,
   input wire logic                         regWr,
   // pins
   input wire logic                         sharedPinIn,
   input wire logic [DATA_WIDTH-1:0]        txBusDataCh2,
   input wire logic                         txBusPayloadIndCh2,
   input wire logic                         txBusPathStartIndCh2,
   // outputs watched
   input wire logic                         ingressCodeViolationCh6,
   input wire logic                         ingressNegRailCh6,
   input wire logic                         parityErrorPulse,
   input wire tx_bus_parity_pkg::pin_role_t pinRole
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // direct writes only: indirect writes also load the sense and scope bits, but the shadow does not follow them
   logic [1:0] ctrlShadow;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrlShadow <= 2'b00;
      end else if (regWr && regAddr == `OFS_IF_CTRL_BYTE2) begin
         ctrlShadow <= regWrData[1:0];
      end
   end
   wire chanWr = regWr && regAddr == `OFS_CHAN_CTRL;
   property p_role_bus;
      chanWr && regWrData[0] |=> pinRole == tx_bus_parity_pkg::ROLE_PARITY;
   endproperty
   a_role_bus: assert property (p_role_bus) else $error("bus enable gave no parity role");
   property p_role_cv;
      chanWr && regWrData[3:0] == 4'b1010 |=> pinRole == tx_bus_parity_pkg::ROLE_CODE_VIOL;
   endproperty
   a_role_cv: assert property (p_role_cv) else $error("single rail ingress role wrong");
   property p_role_neg;
      chanWr && regWrData[3:0] == 4'b1110 |=> pinRole == tx_bus_parity_pkg::ROLE_NEG_RAIL;
   endproperty
   a_role_neg: assert property (p_role_neg) else $error("dual rail ingress role wrong");
   property p_role_off;
      chanWr && !regWrData[0] && !(regWrData[1] && regWrData[3]) |=> pinRole == tx_bus_parity_pkg::ROLE_IDLE;
   endproperty
   a_role_off: assert property (p_role_off) else $error("role not idle");
   property p_parity;
      $past(pinRole, 1) == tx_bus_parity_pkg::ROLE_PARITY && $past(pinRole, 4) == tx_bus_parity_pkg::ROLE_PARITY
         && $past(ctrlShadow, 4) == ctrlShadow |-> parityErrorPulse == (^$past(txBusDataCh2, 3) ^ ctrlShadow[0]
         ^ (ctrlShadow[1] & ($past(txBusPayloadIndCh2, 3) ^ $past(txBusPathStartIndCh2, 3))) ^ $past(sharedPinIn, 3));
   endproperty
   a_parity: assert property (p_parity) else $error("parity error pulse wrong");
   property p_refuse;
      pinRole != tx_bus_parity_pkg::ROLE_PARITY [*4] |=> !parityErrorPulse;
   endproperty
   a_refuse: assert property (p_refuse) else $error("parity checked outside bus role");
   property p_cv;
      $past(pinRole, 1) == $past(pinRole, 4) |-> ingressCodeViolationCh6
         == ($past(pinRole, 1) == tx_bus_parity_pkg::ROLE_CODE_VIOL && $past(sharedPinIn, 3));
   endproperty
   a_cv: assert property (p_cv) else $error("code violation output wrong");
   property p_neg;
      $past(pinRole, 1) == $past(pinRole, 4) |-> ingressNegRailCh6
         == ($past(pinRole, 1) == tx_bus_parity_pkg::ROLE_NEG_RAIL && $past(sharedPinIn, 3));
   endproperty
   a_neg: assert property (p_neg) else $error("negative rail output wrong");
endmodule : tx_bus_parity_props

bind tx_bus_parity_pin_mux tx_bus_parity_props #(.DATA_WIDTH(DATA_WIDTH), .ERR_COUNT_WIDTH(ERR_COUNT_WIDTH))
   tx_bus_parity_props_inst (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
   .sharedPinIn(sharedPinIn), .txBusDataCh2(txBusDataCh2), .txBusPayloadIndCh2(txBusPayloadIndCh2),
   .txBusPathStartIndCh2(txBusPathStartIndCh2), .ingressCodeViolationCh6(ingressCodeViolationCh6),
   .ingressNegRailCh6(ingressNegRailCh6), .parityErrorPulse(parityErrorPulse), .pinRole(pinRole));

// File: dv/tx_bus_source_model.sv
`timescale 1ns/1ps

module tx_bus_source_model (
   // clock
   input  wire logic       clk,
   // configuration
   input  wire logic       lineMode,
   input  wire logic       wideScope,
   input  wire logic       oddSense,
   input  wire logic       corrupt,
   // pins towards the device
   output      logic       sharedPinIn,
   output      logic [7:0] txBusDataCh2,
   output      logic       txBusPayloadIndCh2,
   output      logic       txBusPathStartIndCh2
);
   logic [7:0] step;
   logic       pl;
   logic       ps;
   initial begin
      step = 8'h00;
      {sharedPinIn, txBusDataCh2, txBusPayloadIndCh2, txBusPathStartIndCh2} = 11'h000;
   end
   // new byte every clock, so data never sit still; the indicators follow bits of the step count and can hold
   always @(posedge clk) begin
      pl = step[0] ^ step[3];
      ps = step[2] & step[1];
      step <= step + 8'h01;
      txBusDataCh2 <= step;
      txBusPayloadIndCh2 <= pl;
      txBusPathStartIndCh2 <= ps;
      sharedPinIn <= lineMode ? step[1] : (^step ^ (wideScope & (pl ^ ps)) ^ oddSense ^ corrupt);
   end
endmodule : tx_bus_source_model

// File: dv/tb_tx_bus_parity_pin_mux.sv
`timescale 1ns/1ps
`include "tx_bus_parity_regs.svh"

module tb_tx_bus_parity_pin_mux;
   logic clk, reset, regWr, regRd, pin, pl, ps, cvOut, negOut, pulse, irq;
   logic lineMode, wideScope, oddSense, corrupt;
   logic [7:0] data;
   tx_bus_parity_pkg::reg_addr_t regAddr;
   tx_bus_parity_pkg::reg_byte_t regWrData, regRdData;
   tx_bus_parity_pkg::pin_role_t pinRole;
   int failCount = 0;
   int cmpCount = 0;
   int pulseCount = 0;
   int cvCount = 0;
   int negCount = 0;
   int base;
   int cvBase;
   int negBase;
   localparam logic [7:0] CTL [5] = '{8'h0a, 8'h0e, 8'h02, 8'h08, 8'h0b};
   localparam logic [7:0] STS [5] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h01};
   localparam logic [7:0] ROL [5] = '{8'h02, 8'h03, 8'h00, 8'h00, 8'h01};

   tx_bus_parity_pin_mux tx_bus_parity_pin_mux_inst (.clk(clk), .reset(reset), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sharedPinIn(pin),
      .txBusDataCh2(data), .txBusPayloadIndCh2(pl), .txBusPathStartIndCh2(ps), .ingressCodeViolationCh6(cvOut),
      .ingressNegRailCh6(negOut), .parityErrorPulse(pulse), .pinRole(pinRole), .irq(irq));
   tx_bus_source_model tx_bus_source_model_inst (.clk(clk), .lineMode(lineMode), .wideScope(wideScope),
      .oddSense(oddSense), .corrupt(corrupt), .sharedPinIn(pin), .txBusDataCh2(data),
      .txBusPayloadIndCh2(pl), .txBusPathStartIndCh2(ps));

   // ****************************************
   // helpers
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (pulse === 1'b1) pulseCount <= pulseCount + 1;
      if (cvOut === 1'b1) cvCount <= cvCount + 1;
      if (negOut === 1'b1) negCount <= negCount + 1;
   end
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      cmpCount++;
      if (got !== exp) begin
         failCount++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check8
   task automatic wr(input tx_bus_parity_pkg::reg_addr_t a, input tx_bus_parity_pkg::reg_byte_t d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input tx_bus_parity_pkg::reg_addr_t a, input tx_bus_parity_pkg::reg_byte_t exp);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      // data stand one cycle only: take them at the edge that closes it
      @(posedge clk);
      check8(regRdData, exp);
   endtask : rd
   task printVerdict();
      $display("compares %0d mismatches %0d", cmpCount, failCount);
      if (failCount == 0 && cmpCount > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : printVerdict
   initial begin
      #400000;
      failCount++;
      printVerdict();
   end

   // ****************************************
   // sequence
   // ****************************************
   initial begin
      {reset, regWr, regRd, regAddr, regWrData} = {1'b1, 26'h0000000};
      {lineMode, wideScope, oddSense, corrupt} = 4'h0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      rd(`OFS_IF_CTRL_BYTE2, `RST_IF_CTRL_BYTE2);
      rd(`OFS_CHAN_CTRL, `RST_CHAN_CTRL);
      rd(`OFS_PARITY_ERR_COUNT, `RST_BYTE);
      rd(16'h0200, 8'h00);
      wr(`OFS_IRQ_STATUS, 8'hff);
      rd(`OFS_IRQ_STATUS, `RST_IRQ);
      wr(`OFS_INDIRECT_HI, `IND_IF_CTRL_HI);
      wr(`OFS_INDIRECT_LO, `IND_IF_CTRL_LO);
      wr(`OFS_INDIRECT_DATA, 8'hc0);
      rd(`OFS_IF_CTRL_BYTE2, 8'hc0);
      wr(`OFS_IF_CTRL_BYTE2, 8'h30);
      rd(`OFS_INDIRECT_DATA, 8'h30);
      wr(`OFS_INDIRECT_LO, 8'h3a);
      rd(`OFS_INDIRECT_DATA, 8'h00);
      wr(`OFS_IRQ_ENABLE, 8'h01);
      wr(`OFS_CHAN_CTRL, 8'h01);
      // all four sense and scope settings, clean then with four bad bytes
      for (int c = 0; c < 4; c++) begin
         wr(`OFS_IF_CTRL_BYTE2, 8'(c));
         oddSense <= c[0];
         wideScope <= c[1];
         repeat (6) @(posedge clk);
         wr(`OFS_IRQ_CLEAR, 8'h03);
         repeat (8) @(posedge clk);
         rd(`OFS_IRQ_STATUS, 8'h00);
         check8({7'h00, irq}, 8'h00);
         base = pulseCount;
         corrupt <= 1'b1;
         repeat (4) @(posedge clk);
         corrupt <= 1'b0;
         repeat (6) @(posedge clk);
         rd(`OFS_IRQ_STATUS, 8'h01);
         check8({7'h00, irq}, 8'h01);
         check8(8'(pulseCount - base), 8'h04);
      end
      wr(`OFS_IRQ_ENABLE, 8'h00);
      rd(`OFS_IRQ_STATUS, 8'h01);
      check8({7'h00, irq}, 8'h00);
      lineMode <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         wr(`OFS_CHAN_CTRL, CTL[i]);
         repeat (8) @(posedge clk);
         wr(`OFS_IRQ_CLEAR, 8'h03);
         cvBase = cvCount;
         negBase = negCount;
         repeat (8) @(posedge clk);
         rd(`OFS_IRQ_STATUS, STS[i]);
         check8({6'h00, pinRole}, ROL[i]);
         check8({7'h00, cvCount != cvBase}, {7'h00, i == 0});
         check8({7'h00, negCount != negBase}, {7'h00, i == 1});
      end
      printVerdict();
   end
endmodule : tb_tx_bus_parity_pin_mux
